/* pkg/operand_pkg.sv */
// Constants, types and register map of the operand decoder
package operand_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] OFF_OP_KIND = 8'h00;
  localparam logic [7:0] OFF_OP_VAL = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_STATE_WORD = 8'h10;
  localparam logic [7:0] OFF_FLAG_ACT = 8'h14;
  localparam logic [7:0] OFF_FLAG_SAVE = 8'h18;
  localparam logic [7:0] OFF_ALU = 8'h1c;
  localparam logic [7:0] OFF_CLK_CNT = 8'h20;
  localparam logic [7:0] OFF_GREG_BASE = 8'h40;
  localparam logic [7:0] OFF_GREG_LAST = 8'h5c;
  localparam logic [7:0] OFF_PAIR_BASE = 8'h60;
  localparam logic [7:0] OFF_PAIR_LAST = 8'h6c;
  // Byte register numbers
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam int NUM_GREG = 8;
  localparam int NUM_PAIR = 4;
  localparam int NUM_FLAG = 4;
  // Address windows
  localparam logic [15:0] SDIR_FIRST = 16'hfe20;
  localparam logic [15:0] SDIR_LAST = 16'hff1f;
  localparam logic [15:0] CALLT_FIRST = 16'h0040;
  localparam logic [15:0] CALLT_LAST = 16'h007f;
  // Status word bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_HALF = 4;
  localparam int FLG_ZERO = 6;
  localparam int FLG_INT_EN = 7;
  // Flag action field: three bits per flag, carry/half/zero/int enable
  localparam int ACT_W = 3;
  // Computed-result register fields
  localparam int ALU_CARRY = 8;
  localparam int ALU_HALF = 9;
  localparam int ALU_INT_EN = 10;
  // Result register fault bit
  localparam int RES_FAULT = 16;
  // Reset values
  localparam logic [7:0] STATE_WORD_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  typedef enum logic [2:0] {
    ACT_KEEP = 3'b000,
    ACT_CLEAR = 3'b001,
    ACT_SET = 3'b010,
    ACT_CALC = 3'b011,
    ACT_RESTORE = 3'b100
  } flag_act_t;

  typedef enum logic [3:0] {
    OPK_REG = 4'b0000,
    OPK_PAIR = 4'b0001,
    OPK_SDIR = 4'b0010,
    OPK_SDIR_W = 4'b0011,
    OPK_ABS = 4'b0100,
    OPK_ABS_W = 4'b0101,
    OPK_CALLT = 4'b0110,
    OPK_BRANCH = 4'b0111,
    OPK_BIT = 4'b1000,
    OPK_IMM_B = 4'b1001,
    OPK_IMM_W = 4'b1010,
    OPK_ACC_B = 4'b1011,
    OPK_ACC_W = 4'b1100
  } opnd_kind_t;
endpackage

/* rtl/flag_action.sv */
// Next value of one status flag from its action code
`timescale 1ns/1ps
module flag_action
  import operand_pkg::*;
(
  input wire logic cur,
  input wire flag_act_t act,
  input wire logic calc,
  input wire logic saved,
  output logic nxt
);
  always_comb begin
    case (act)
      ACT_KEEP: nxt = cur;
      ACT_CLEAR: nxt = 1'b0;
      ACT_SET: nxt = 1'b1;
      ACT_CALC: nxt = calc;
      ACT_RESTORE: nxt = saved;
      default: nxt = cur;
    endcase
  end
endmodule // flag_action

/* rtl/operand_decoder.sv */
// APB-mapped operand decoder with byte registers, pairs and status word
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Eight byte registers 0..7 are X, A, C, B, E, D, L, H.
// - Four 16-bit pairs 0..3 are AX, BC, DE, HL from byte registers.
// - Short direct byte operand reaches only FE20H to FF1FH.
// - Short direct word operand uses same window, even addresses only.
// - Absolute operand spans 0000H-FFFFH; word transfers need even address.
// - Call-table operand selects only even addresses 0040H to 007FH.
// - Branch displacement is signed 8-bit, sign-extended, added to PC.
// - Bit-position operand is 3 bits selecting one of eight bits.
// - Word immediates are 16 bits, byte immediates 8 bits.
// - A is the byte accumulator, AX the word accumulator.
// - Upper and lower bytes of each pair are handled separately.
// - Status word holds carry, half carry, zero and interrupt enable.
// - Each flag stays, clears, sets or takes the computed result.
// - Restoring instructions load a flag from its saved value.
// - Each instruction clock equals one CPU clock cycle.
module operand_decoder
  import operand_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] operand,
  output logic operand_fault,
  output logic [7:0] program_state_word
);
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] greg_ff [NUM_GREG];
  logic [7:0] nxt_greg [NUM_GREG];
  logic [3:0] op_kind_ff, nxt_op_kind;
  logic [15:0] op_val_ff, nxt_op_val;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] state_word_ff, nxt_state_word;
  logic [7:0] save_ff, nxt_save;
  logic [10:0] alu_ff, nxt_alu;
  logic [31:0] clk_cnt_ff, nxt_clk_cnt;
  logic go_ff, nxt_go;
  logic [15:0] operand_ff, nxt_operand;
  logic fault_ff, nxt_fault;
  logic wr_en;
  logic [15:0] dec_val;
  logic dec_fault;
  logic [15:0] branch_tgt;
  logic [7:0] reg_pick;
  logic [15:0] pair_pick;
  logic [NUM_FLAG-1:0] flag_new;

  function automatic int flag_pos(input int i);
    case (i)
      0: flag_pos = FLG_CARRY;
      1: flag_pos = FLG_HALF;
      2: flag_pos = FLG_ZERO;
      default: flag_pos = FLG_INT_EN;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) &&
      (a <= OFF_CLK_CNT ||
       (a >= OFF_GREG_BASE && a <= OFF_PAIR_LAST));
  endfunction

  function automatic logic [15:0] pair_of(input logic [1:0] n,
                                          input logic [7:0] g [NUM_GREG]);
    pair_of = {g[{n, 1'b1}], g[{n, 1'b0}]};
  endfunction

  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign reg_pick = greg_ff[op_val_ff[2:0]];
  assign pair_pick = pair_of(op_val_ff[1:0], greg_ff);
  assign branch_tgt = pc_ff + {{8{op_val_ff[7]}}, op_val_ff[7:0]};

  // APB slave: answer in the access cycle, read data taken at setup
  always_comb begin
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !mapped(paddr);
    nxt_prdata = 32'h0000_0000;
    if (psel && !penable && mapped(paddr)) begin
      if (paddr >= OFF_GREG_BASE && paddr <= OFF_GREG_LAST) begin
        nxt_prdata = {24'h00_0000, greg_ff[paddr[4:2]]};
      end else if (paddr >= OFF_PAIR_BASE && paddr <= OFF_PAIR_LAST) begin
        nxt_prdata = {16'h0000, pair_of(paddr[3:2], greg_ff)};
      end else begin
        case (paddr)
          OFF_OP_KIND: nxt_prdata = {28'h000_0000, op_kind_ff};
          OFF_OP_VAL: nxt_prdata = {16'h0000, op_val_ff};
          OFF_RESULT: nxt_prdata = {15'h0, fault_ff, operand_ff};
          OFF_PC: nxt_prdata = {16'h0000, pc_ff};
          OFF_STATE_WORD: nxt_prdata = {24'h00_0000, state_word_ff};
          OFF_FLAG_SAVE: nxt_prdata = {24'h00_0000, save_ff};
          OFF_ALU: nxt_prdata = {21'h0, alu_ff};
          OFF_CLK_CNT: nxt_prdata = clk_cnt_ff;
          default: nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Operand decode from the latched kind and value
  always_comb begin
    dec_val = 16'h0000;
    dec_fault = 1'b0;
    case (opnd_kind_t'(op_kind_ff))
      OPK_REG: dec_val = {8'h00, reg_pick};
      OPK_PAIR: dec_val = pair_pick;
      OPK_SDIR: dec_val = SDIR_FIRST + {8'h00, op_val_ff[7:0]};
      OPK_SDIR_W: begin
        dec_val = SDIR_FIRST + {8'h00, op_val_ff[7:0]};
        dec_fault = op_val_ff[0];
      end
      OPK_ABS: dec_val = op_val_ff;
      OPK_ABS_W: begin
        dec_val = op_val_ff;
        dec_fault = op_val_ff[0];
      end
      OPK_CALLT: dec_val = CALLT_FIRST +
        {10'h000, op_val_ff[4:0], 1'b0};
      OPK_BRANCH: dec_val = branch_tgt;
      OPK_BIT: dec_val = 16'h0001 << op_val_ff[2:0];
      OPK_IMM_B: dec_val = {8'h00, op_val_ff[7:0]};
      OPK_IMM_W: dec_val = op_val_ff;
      OPK_ACC_B: dec_val = {8'h00, greg_ff[REG_A]};
      OPK_ACC_W: dec_val = {greg_ff[REG_A], greg_ff[REG_X]};
      default: dec_fault = 1'b1;
    endcase
  end

  // Per-flag action units
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAG; gi++) begin : g_flag
      logic calc_bit;
      always_comb begin
        case (gi)
          0: calc_bit = alu_ff[ALU_CARRY];
          1: calc_bit = alu_ff[ALU_HALF];
          2: calc_bit = (alu_ff[7:0] == 8'h00);
          default: calc_bit = alu_ff[ALU_INT_EN];
        endcase
      end
      flag_action u_flag (
        .cur(state_word_ff[flag_pos(gi)]),
        .act(flag_act_t'(pwdata[ACT_W*gi +: ACT_W])),
        .calc(calc_bit),
        .saved(save_ff[flag_pos(gi)]),
        .nxt(flag_new[gi])
      );
    end
  endgenerate

  // Software-visible state and decode results
  always_comb begin
    nxt_greg = greg_ff;
    nxt_op_kind = op_kind_ff;
    nxt_op_val = op_val_ff;
    nxt_pc = pc_ff;
    nxt_state_word = state_word_ff;
    nxt_save = save_ff;
    nxt_alu = alu_ff;
    nxt_clk_cnt = clk_cnt_ff + 32'h0000_0001;
    nxt_go = wr_en && (paddr == OFF_OP_VAL);
    nxt_operand = operand_ff;
    nxt_fault = fault_ff;
    if (go_ff) begin
      nxt_operand = dec_val;
      nxt_fault = dec_fault;
      if (opnd_kind_t'(op_kind_ff) == OPK_BRANCH) begin
        nxt_pc = branch_tgt;
      end
    end
    if (wr_en) begin
      if (paddr >= OFF_GREG_BASE && paddr <= OFF_GREG_LAST) begin
        nxt_greg[paddr[4:2]] = pwdata[7:0];
      end else if (paddr >= OFF_PAIR_BASE && paddr <= OFF_PAIR_LAST) begin
        nxt_greg[{paddr[3:2], 1'b1}] = pwdata[15:8];
        nxt_greg[{paddr[3:2], 1'b0}] = pwdata[7:0];
      end else begin
        case (paddr)
          OFF_OP_KIND: nxt_op_kind = pwdata[3:0];
          OFF_OP_VAL: nxt_op_val = pwdata[15:0];
          OFF_PC: nxt_pc = pwdata[15:0];
          OFF_STATE_WORD: nxt_state_word = pwdata[7:0];
          OFF_FLAG_ACT: begin
            for (int i = 0; i < NUM_FLAG; i++) begin
              nxt_state_word[flag_pos(i)] = flag_new[i];
            end
          end
          OFF_FLAG_SAVE: nxt_save = pwdata[7:0];
          OFF_ALU: nxt_alu = pwdata[10:0];
          default: nxt_state_word = nxt_state_word;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_GREG; i++) begin
        greg_ff[i] <= 8'h00;
      end
      op_kind_ff <= 4'h0;
      op_val_ff <= 16'h0000;
      pc_ff <= PC_RST;
      state_word_ff <= STATE_WORD_RST;
      save_ff <= 8'h00;
      alu_ff <= 11'h000;
      clk_cnt_ff <= 32'h0000_0000;
      go_ff <= 1'b0;
      operand_ff <= 16'h0000;
      fault_ff <= 1'b0;
    end else begin
      greg_ff <= nxt_greg;
      op_kind_ff <= nxt_op_kind;
      op_val_ff <= nxt_op_val;
      pc_ff <= nxt_pc;
      state_word_ff <= nxt_state_word;
      save_ff <= nxt_save;
      alu_ff <= nxt_alu;
      clk_cnt_ff <= nxt_clk_cnt;
      go_ff <= nxt_go;
      operand_ff <= nxt_operand;
      fault_ff <= nxt_fault;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign operand = operand_ff;
  assign operand_fault = fault_ff;
  assign program_state_word = state_word_ff;

  // Checks
  property p_reg_sel;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_REG |=>
      operand_ff == {8'h00, $past(reg_pick)};
  endproperty
  a_reg_sel: assert property (p_reg_sel)
    else $error("byte register select wrong");

  property p_pair_sel;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_PAIR |=> operand_ff == $past(pair_pick);
  endproperty
  a_pair_sel: assert property (p_pair_sel)
    else $error("register pair select wrong");

  property p_sdir_win;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_SDIR |=>
      operand_ff >= SDIR_FIRST && operand_ff <= SDIR_LAST && !fault_ff;
  endproperty
  a_sdir_win: assert property (p_sdir_win)
    else $error("short direct address out of window");

  property p_sdir_even;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_SDIR_W |=>
      fault_ff == $past(op_val_ff[0]) && operand_ff >= SDIR_FIRST;
  endproperty
  a_sdir_even: assert property (p_sdir_even)
    else $error("short direct word parity check wrong");

  property p_abs_even;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_ABS_W |=>
      fault_ff == operand_ff[0] && operand_ff == $past(op_val_ff);
  endproperty
  a_abs_even: assert property (p_abs_even)
    else $error("absolute word address check wrong");

  property p_callt;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_CALLT |=> !operand_ff[0] &&
      operand_ff >= CALLT_FIRST && operand_ff <= CALLT_LAST;
  endproperty
  a_callt: assert property (p_callt)
    else $error("call table address out of window");

  property p_branch;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_BRANCH && !wr_en |=>
      pc_ff == $past(branch_tgt) && operand_ff == pc_ff;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");

  property p_bit;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_BIT |=>
      $onehot(operand_ff) && operand_ff[$past(op_val_ff[2:0])];
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit position mask wrong");

  property p_acc_w;
    @(posedge pclk) disable iff (!presetn)
    go_ff && op_kind_ff == OPK_ACC_W |=>
      operand_ff[15:8] == $past(greg_ff[REG_A]);
  endproperty
  a_acc_w: assert property (p_acc_w)
    else $error("word accumulator high byte not A");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFF_FLAG_ACT && pwdata[2:0] == ACT_CLEAR
      ##1 !(wr_en && paddr == OFF_FLAG_ACT) [*2] |->
      !state_word_ff[FLG_CARRY];
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("carry not cleared");

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFF_FLAG_ACT && pwdata[8:6] == ACT_RESTORE |=>
      state_word_ff[FLG_ZERO] == $past(save_ff[FLG_ZERO]);
  endproperty
  a_restore: assert property (p_restore)
    else $error("zero flag not restored from saved value");

  property p_clk_cnt;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> clk_cnt_ff == $past(clk_cnt_ff) + 32'h0000_0001;
  endproperty
  a_clk_cnt: assert property (p_clk_cnt)
    else $error("instruction clock count skipped");
endmodule // operand_decoder

/* verif/prog_mem_model.sv */
// Program memory model handing operand records to the bench
`timescale 1ns/1ps
module prog_mem_model
  import operand_pkg::*;
(
  input wire logic [4:0] idx,
  output logic [3:0] kind,
  output logic [15:0] val
);
  // Each record is {kind, operand field}, boundary values first
  localparam logic [19:0] ROM [15] = '{
    {4'h2, 16'h0000},
    {4'h2, 16'h00ff},
    {4'h3, 16'h0010},
    {4'h3, 16'h0011},
    {4'h4, 16'hffff},
    {4'h5, 16'hfffe},
    {4'h5, 16'h0001},
    {4'h6, 16'h0000},
    {4'h6, 16'h001f},
    {4'h8, 16'h0007},
    {4'h8, 16'h0000},
    {4'h9, 16'h1234},
    {4'ha, 16'hbeef},
    {4'hd, 16'h0001},
    {4'hf, 16'hffff}
  };
  always_comb begin
    kind = ROM[idx][19:16];
    val = ROM[idx][15:0];
  end
endmodule // prog_mem_model

/* verif/cpu_operand_decoder_tb_top.sv */
// Self-checking bench for the APB operand decoder
`timescale 1ns/1ps
module cpu_operand_decoder_tb_top;
  import operand_pkg::*;
  typedef struct {
    logic rd; logic op; logic ps; logic [31:0] d; logic e;
  } note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] operand;
  logic operand_fault;
  logic [7:0] program_state_word;
  logic [4:0] mem_idx = 5'h00;
  logic [3:0] mem_kind;
  logic [15:0] mem_val;
  note_t notes[$];
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] seed = 32'd49893;
  logic [7:0] gr [8];
  logic [15:0] pc_m;
  logic [16:0] last_res;

  operand_decoder operand_decoder_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .operand(operand), .operand_fault(operand_fault),
    .program_state_word(program_state_word));
  prog_mem_model prog_mem_model_inst (.idx(mem_idx), .kind(mem_kind),
    .val(mem_val));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("FAIL %0t %s", $time, msg);
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    check_count++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic cmp1(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp)
      fail($sformatf("%s got %b exp %b", msg, got, exp));
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One APB transfer; the note is judged by the monitor
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input note_t n);
    int i;
    notes.push_back(n);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      fail("no pready");
      close_out();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    apb(1'b1, a, d, '{1'b0, 1'b0, 1'b0, 32'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0, input logic op = 1'b0,
                    input logic ps = 1'b0);
    apb(1'b0, a, 32'h0, '{1'b1, op, ps, d, e});
  endtask

  always @(posedge pclk) begin
    note_t n;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0)
        fail("answer with no request");
      else begin
        n = notes.pop_front();
        cmp1(pslverr, n.e, "pslverr");
        if (n.rd)
          cmp32(prdata, n.d, "prdata");
        if (n.op)
          cmp32({15'h0, operand_fault, operand}, n.d, "operand port");
        if (n.ps)
          cmp32({24'h0, program_state_word}, n.d, "status port");
      end
    end
  end

  function automatic logic [16:0] exp_dec(input logic [3:0] k,
                                          input logic [15:0] v);
    case (k)
      4'h0: return {9'h0, gr[v[2:0]]};
      4'h1: return {1'b0, gr[{v[1:0], 1'b1}], gr[{v[1:0], 1'b0}]};
      4'h2: return {1'b0, SDIR_FIRST + {8'h0, v[7:0]}};
      4'h3: return {v[0], SDIR_FIRST + {8'h0, v[7:0]}};
      4'h4: return {1'b0, v};
      4'h5: return {v[0], v};
      4'h6: return {1'b0, CALLT_FIRST + {10'h0, v[4:0], 1'b0}};
      4'h7: return {1'b0, pc_m + {{8{v[7]}}, v[7:0]}};
      4'h8: return {1'b0, 16'h1 << v[2:0]};
      4'h9: return {9'h0, v[7:0]};
      4'ha: return {1'b0, v};
      4'hb: return {9'h0, gr[REG_A]};
      4'hc: return {1'b0, gr[REG_A], gr[REG_X]};
      default: return {1'b1, 16'h0};
    endcase
  endfunction

  task automatic decode(input logic [3:0] k, input logic [15:0] v);
    last_res = exp_dec(k, v);
    wr(OFF_OP_KIND, {28'h0, k});
    wr(OFF_OP_VAL, {16'h0, v});
    repeat (2) @(posedge pclk);
    if (k == 4'h7)
      pc_m = last_res[15:0];
    rd(OFF_RESULT, {15'h0, last_res}, 1'b0, 1'b1);
  endtask

  task automatic flags(input logic [11:0] act, input logic [7:0] p,
                       input logic [7:0] sv, input logic [10:0] alu);
    int pos [4] = '{FLG_CARRY, FLG_HALF, FLG_ZERO, FLG_INT_EN};
    logic [3:0] calc;
    logic [7:0] e;
    calc = {alu[ALU_INT_EN], alu[7:0] == 8'h0, alu[ALU_HALF],
            alu[ALU_CARRY]};
    e = p;
    for (int f = 0; f < NUM_FLAG; f++) begin
      case (act[3*f +: 3])
        3'h1: e[pos[f]] = 1'b0;
        3'h2: e[pos[f]] = 1'b1;
        3'h3: e[pos[f]] = calc[f];
        3'h4: e[pos[f]] = sv[pos[f]];
        default: ;
      endcase
    end
    wr(OFF_STATE_WORD, {24'h0, p});
    wr(OFF_FLAG_SAVE, {24'h0, sv});
    wr(OFF_ALU, {21'h0, alu});
    wr(OFF_FLAG_ACT, {20'h0, act});
    repeat (2) @(posedge pclk);
    rd(OFF_STATE_WORD, {24'h0, e}, 1'b0, 1'b0, 1'b1);
  endtask

  initial begin
    #2500000;
    fail("run limit");
    close_out();
  end

  initial begin
    logic [31:0] r;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    pc_m = PC_RST;
    rd(OFF_STATE_WORD, {24'h0, STATE_WORD_RST}, 1'b0, 1'b0, 1'b1);
    rd(OFF_PC, {16'h0, PC_RST});
    for (int i = 0; i < NUM_GREG; i++) begin
      gr[i] = 8'(xs());
      wr(OFF_GREG_BASE + 8'(4 * i), {24'h0, gr[i]});
    end
    for (int i = 0; i < NUM_PAIR; i++)
      rd(OFF_PAIR_BASE + 8'(4 * i), {16'h0, gr[2*i+1], gr[2*i]});
    wr(OFF_PAIR_BASE + 8'h08, 32'h0000_a55a);
    gr[5] = 8'ha5;
    gr[4] = 8'h5a;
    rd(OFF_GREG_BASE + 8'h10, 32'h0000_005a);
    rd(OFF_GREG_BASE + 8'h14, 32'h0000_00a5);
    for (int i = 0; i < NUM_GREG; i++)
      decode(4'h0, 16'(i));
    for (int i = 0; i < NUM_PAIR; i++)
      decode(4'h1, 16'(i));
    decode(4'hb, 16'h0);
    decode(4'hc, 16'h0);
    for (int i = 0; i < 15; i++) begin
      mem_idx <= 5'(i);
      repeat (2) @(posedge pclk);
      decode(mem_kind, mem_val);
    end
    wr(OFF_PC, 32'h0000_1000);
    pc_m = 16'h1000;
    decode(4'h7, 16'h0080);
    decode(4'h7, 16'h007f);
    rd(OFF_PC, {16'h0, pc_m});
    for (int i = 0; i < 40; i++) begin
      r = xs();
      decode(4'(r[19:16] % 13), r[15:0]);
    end
    wr(OFF_RESULT, 32'hffff_ffff);
    rd(OFF_RESULT, {15'h0, last_res}, 1'b0, 1'b1);
    for (int a = 0; a < 6; a++)
      flags({4{3'(a)}}, 8'(xs()), 8'(xs()), 11'(xs()));
    flags({4{3'h3}}, 8'h00, 8'h00, 11'h700);
    flags(12'b100_011_010_001, 8'hff, 8'h00, 11'h001);
    rd(OFF_FLAG_ACT, 32'h0);
    wr(8'h80, 32'h1234_5678, 1'b1);
    rd(8'h80, 32'h0, 1'b1);
    rd(8'h41, 32'h0, 1'b1);
    repeat (2) @(posedge pclk);
    close_out();
  end
endmodule // cpu_operand_decoder_tb_top
